// ### core/spc_pkg.sv
// Register map, field layout, timing and carrier types of synth control
// How it works
// - Lane rate is twenty times DAC rate over interpolation, times M over L.
// - Byte rate is one tenth of the lane rate, from 8b/10b coding.
// - Processing clock rate is one quarter of the byte rate.
// - Frame rate is the byte rate divided by F octets per frame per lane.
// - Frames per processing clock is four divided by F.
// - Synthesizer reference rate is one fortieth of the lane rate.
// - Divider code 2 divides by 1, code 1 by 2, code 0 by 4.
// - Status bit 0 reads 1 while the synthesizer is locked.
// - Status bit 3 reads 1 once calibration has succeeded.
// - Status bit 4 or 5 rises when calibration ends at the band top or foot.
// - A rising edge on control bit 2 starts a new calibration while control bit 0 is set.
`default_nettype none
package spc_pkg;
   localparam int unsigned CLK_MHZ = 100;
   // Band comparator settling time after each band step
   localparam int unsigned SETTLE_NS = 1000;
   localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_CTRL = 10'h280;
   localparam logic [9:0] IDX_STS = 10'h281;
   localparam logic [9:0] IDX_LF0 = 10'h284;
   localparam logic [9:0] IDX_CP = 10'h287;
   localparam logic [9:0] IDX_REFDIV = 10'h289;
   localparam logic [9:0] IDX_RATECFG = 10'h2a0;
   localparam logic [9:0] IDX_LANE = 10'h2a1;
   localparam logic [9:0] IDX_BYTE = 10'h2a2;
   localparam logic [9:0] IDX_PCLK = 10'h2a3;
   localparam logic [9:0] IDX_FRAME = 10'h2a4;
   localparam logic [9:0] IDX_IRQSTS = 10'h2a8;
   localparam logic [9:0] IDX_IRQMASK = 10'h2a9;
   // Field positions
   localparam int unsigned CTRL_EN = 0;
   localparam int unsigned CTRL_RECAL = 2;
   localparam int unsigned STS_LOCK = 0;
   localparam int unsigned STS_CALOK = 3;
   localparam int unsigned STS_LIMHI = 4;
   localparam int unsigned STS_LIMLO = 5;
   // Interrupt bits: cal done, limit high, limit low, lock gain, lock loss
   localparam int unsigned NIRQ = 5;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [31:0] RATECFG_RST = 32'h0000_0000;
   localparam logic [5:0] BAND_MID = 6'h20;
   localparam logic [5:0] BAND_MAX = 6'h3f;
   localparam logic [21:0] LANE_MULT = 22'h000014;
   typedef enum {CAL_OFF, CAL_SETTLE, CAL_DECIDE, CAL_DONE, CAL_LIMIT}
      spc_cal_state_t;
   typedef struct packed {
      logic enable;
      logic [1:0] divSelect;
      logic [2:0] refDivideRatio;
      logic [7:0] loopFilter0;
      logic [7:0] loopFilter1;
      logic [7:0] loopFilter2;
      logic [7:0] chargePump;
   } spc_synth_cfg_t;
   typedef struct packed {
      logic [21:0] laneMbps;
      logic [21:0] byteMhz;
      logic [21:0] pclkMhz;
      logic [21:0] frameMhz;
      logic [21:0] refMhz;
      logic [2:0] framePerProcClockRatio;
   } spc_rates_t;
endpackage
`default_nettype wire

// ### core/spc_synth_ctrl.sv
// Synthesizer control, calibration, status and clock-rate block
`timescale 1ns/1ps
`default_nettype none
module spc_synth_ctrl (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic vcoSlow,
   input wire logic pfdLocked,
   output spc_pkg::spc_synth_cfg_t synthCfg,
   output logic [5:0] vcoBand,
   output spc_pkg::spc_rates_t rates,
   output logic irq
);
   // Divider code to ratio; code 3 treated as divide by 4
   function automatic logic [2:0] divRatio(input logic [1:0] code);
      case (code)
         2'h2: divRatio = 3'h1;
         2'h1: divRatio = 3'h2;
         default: divRatio = 3'h4;
      endcase
   endfunction

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      merge = r;
   endfunction

   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] lf_q [0:3];
   logic [7:0] lf_d [0:3];
   logic [7:0] refDiv_q, refDiv_d;
   logic [31:0] rateCfg_q, rateCfg_d;
   logic [spc_pkg::NIRQ-1:0] irqSts_q, irqSts_d;
   logic [spc_pkg::NIRQ-1:0] irqMask_q, irqMask_d;
   logic [spc_pkg::NIRQ-1:0] irqClr, events;
   logic [9:0] idx;
   logic wrStb, locked, lockPrev_q, lockPrev_d;
   logic [7:0] stsByte;
   spc_pkg::spc_cal_state_t state_q, state_d;
   logic [5:0] band_q, band_d;
   logic dirUp_q, dirUp_d, first_q, first_d;
   logic [7:0] settle_q, settle_d;
   logic calOk_q, calOk_d, limHi_q, limHi_d, limLo_q, limLo_d;
   logic enPrev_q, recalPrev_q, startCal, want;
   spc_pkg::spc_rates_t rates_d;
   logic [21:0] laneRaw;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   assign idx = adr_i[11:2];
   // Write lands on the edge where ack is seen by the master
   assign wrStb = cyc_i & stb_i & we_i & ack_q;
   assign irqClr = (wrStb && idx == spc_pkg::IDX_IRQSTS && sel_i[0]) ?
      dat_i[spc_pkg::NIRQ-1:0] : '0;
   // Status is live so software always sees the current loop state
   assign locked = ctrl_q[spc_pkg::CTRL_EN] & calOk_q & pfdLocked;
   always_comb
   begin
      stsByte = 8'h00;
      stsByte[spc_pkg::STS_LOCK] = locked;
      stsByte[spc_pkg::STS_CALOK] = calOk_q;
      stsByte[spc_pkg::STS_LIMHI] = limHi_q;
      stsByte[spc_pkg::STS_LIMLO] = limLo_q;
   end

   // Bus slave: ack one cycle after the request, read data staged with it
   always_comb
   begin
      ack_d = cyc_i & stb_i & ~ack_q;
      rdat_d = rdat_q;
      ctrl_d = ctrl_q;
      lf_d = lf_q;
      refDiv_d = refDiv_q;
      rateCfg_d = rateCfg_q;
      irqMask_d = irqMask_q;
      if (ack_d)
      begin
         rdat_d = 32'h0000_0000; // Unmapped reads as zero
         case (idx)
            spc_pkg::IDX_CTRL: rdat_d[7:0] = ctrl_q;
            spc_pkg::IDX_STS: rdat_d[7:0] = stsByte;
            spc_pkg::IDX_REFDIV: rdat_d[7:0] = refDiv_q;
            spc_pkg::IDX_RATECFG: rdat_d = rateCfg_q;
            spc_pkg::IDX_LANE: rdat_d[21:0] = rates.laneMbps;
            spc_pkg::IDX_BYTE: rdat_d[21:0] = rates.byteMhz;
            spc_pkg::IDX_PCLK: rdat_d[21:0] = rates.pclkMhz;
            spc_pkg::IDX_FRAME: rdat_d = {5'h00,
               rates.framePerProcClockRatio, 2'h0, rates.frameMhz};
            spc_pkg::IDX_IRQSTS: rdat_d[spc_pkg::NIRQ-1:0] = irqSts_q;
            spc_pkg::IDX_IRQMASK: rdat_d[spc_pkg::NIRQ-1:0] = irqMask_q;
            default:
            begin
               if (idx >= spc_pkg::IDX_LF0 && idx <= spc_pkg::IDX_CP)
                  rdat_d[7:0] = lf_q[idx[1:0]];
            end
         endcase
      end
      if (wrStb)
      begin
         case (idx)
            spc_pkg::IDX_CTRL: ctrl_d = 8'(merge({24'h0, ctrl_q}, dat_i,
               sel_i));
            spc_pkg::IDX_REFDIV: refDiv_d = 8'(merge({24'h0, refDiv_q},
               dat_i, sel_i));
            spc_pkg::IDX_RATECFG: rateCfg_d = merge(rateCfg_q, dat_i, sel_i);
            spc_pkg::IDX_IRQMASK:
               irqMask_d = 5'(merge({27'h0, irqMask_q}, dat_i, sel_i));
            default:
            begin
               if (idx >= spc_pkg::IDX_LF0 && idx <= spc_pkg::IDX_CP)
                  lf_d[idx[1:0]] = 8'(merge({24'h0, lf_q[idx[1:0]]}, dat_i,
                     sel_i));
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
         ctrl_q <= spc_pkg::REG_RST;
         lf_q <= '{default: spc_pkg::REG_RST};
         refDiv_q <= spc_pkg::REG_RST;
         rateCfg_q <= spc_pkg::RATECFG_RST;
         irqMask_q <= '0;
      end
      else
      begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         ctrl_q <= ctrl_d;
         lf_q <= lf_d;
         refDiv_q <= refDiv_d;
         rateCfg_q <= rateCfg_d;
         irqMask_q <= irqMask_d;
      end
   end
   assign ack_o = ack_q;
   assign dat_o = rdat_q;

   // Calibration starts on enable or on a recal rising edge while enabled
   assign startCal = ctrl_q[spc_pkg::CTRL_EN] & (~enPrev_q |
      (ctrl_q[spc_pkg::CTRL_RECAL] & ~recalPrev_q));
   assign want = first_q ? vcoSlow : dirUp_q;
   // Band search: walk one step at a time toward the comparator flip
   always_comb
   begin
      state_d = state_q;
      band_d = band_q;
      dirUp_d = dirUp_q;
      first_d = first_q;
      settle_d = settle_q;
      calOk_d = calOk_q;
      limHi_d = limHi_q;
      limLo_d = limLo_q;
      case (state_q)
         spc_pkg::CAL_SETTLE:
         begin
            if (settle_q == 8'h00) state_d = spc_pkg::CAL_DECIDE;
            else settle_d = settle_q - 8'h01;
         end
         spc_pkg::CAL_DECIDE:
         begin
            first_d = 1'b0;
            dirUp_d = want;
            settle_d = 8'(spc_pkg::SETTLE_CYC - 1);
            state_d = spc_pkg::CAL_SETTLE;
            if (!first_q && vcoSlow != dirUp_q)
            begin
               calOk_d = 1'b1;
               state_d = spc_pkg::CAL_DONE;
            end
            else if (want && band_q == spc_pkg::BAND_MAX)
            begin
               limHi_d = 1'b1;
               state_d = spc_pkg::CAL_LIMIT;
            end
            else if (!want && band_q == 6'h00)
            begin
               limLo_d = 1'b1;
               state_d = spc_pkg::CAL_LIMIT;
            end
            else if (want) band_d = band_q + 6'h01;
            else band_d = band_q - 6'h01;
         end
         spc_pkg::CAL_OFF, spc_pkg::CAL_DONE, spc_pkg::CAL_LIMIT: ;
         default: state_d = spc_pkg::CAL_OFF;
      endcase
      if (startCal)
      begin
         state_d = spc_pkg::CAL_SETTLE;
         band_d = spc_pkg::BAND_MID;
         first_d = 1'b1;
         settle_d = 8'(spc_pkg::SETTLE_CYC - 1);
         {calOk_d, limHi_d, limLo_d} = 3'b000;
      end
      if (!ctrl_q[spc_pkg::CTRL_EN])
      begin
         state_d = spc_pkg::CAL_OFF;
         {calOk_d, limHi_d, limLo_d} = 3'b000;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state_q <= spc_pkg::CAL_OFF;
         band_q <= spc_pkg::BAND_MID;
         {dirUp_q, first_q, calOk_q, limHi_q, limLo_q} <= 5'b00000;
         settle_q <= 8'h00;
         enPrev_q <= 1'b0;
         recalPrev_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         band_q <= band_d;
         {dirUp_q, first_q, calOk_q, limHi_q, limLo_q} <=
            {dirUp_d, first_d, calOk_d, limHi_d, limLo_d};
         settle_q <= settle_d;
         enPrev_q <= ctrl_q[spc_pkg::CTRL_EN];
         recalPrev_q <= ctrl_q[spc_pkg::CTRL_RECAL];
      end
   end
   assign vcoBand = band_q;

   // Sticky events; a new event beats a same-cycle write-one clear
   assign events = {~locked & lockPrev_q, locked & ~lockPrev_q,
      limLo_d & ~limLo_q, limHi_d & ~limHi_q, calOk_d & ~calOk_q};
   always_comb
   begin
      irqSts_d = (irqSts_q & ~irqClr) | events;
      lockPrev_d = locked;
   end
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         irqSts_q <= '0;
         lockPrev_q <= 1'b0;
      end
      else
      begin
         irqSts_q <= irqSts_d;
         lockPrev_q <= lockPrev_d;
      end
   end
   assign irq = |(irqSts_q & irqMask_q);

   // Rate calculator: cfg [15:0] DAC MHz, [17:16] log2 interp,
   // [18] log2 M, [21:20] log2 L, [24] log2 F; shifts keep the lane rate divider-free
   assign laneRaw = ((22'(rateCfg_q[15:0]) * spc_pkg::LANE_MULT) <<
      rateCfg_q[18]) >> (3'(rateCfg_q[17:16]) + 3'(rateCfg_q[21:20]));
   always_comb
   begin
      rates_d.laneMbps = laneRaw;
      rates_d.byteMhz = laneRaw / 22'd10;
      rates_d.pclkMhz = laneRaw / 22'd40;
      rates_d.refMhz = laneRaw / 22'd40;
      rates_d.frameMhz = (laneRaw / 22'd10) >> rateCfg_q[24];
      rates_d.framePerProcClockRatio = 3'h4 >> rateCfg_q[24];
   end
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n) rates <= '0;
      else rates <= rates_d;
   end

   // Configuration handed to the analog loop, registered
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n) synthCfg <= '0;
      else
      begin
         synthCfg.enable <= ctrl_q[spc_pkg::CTRL_EN];
         synthCfg.divSelect <= refDiv_q[1:0];
         synthCfg.refDivideRatio <= divRatio(refDiv_q[1:0]);
         synthCfg.loopFilter0 <= lf_q[0];
         synthCfg.loopFilter1 <= lf_q[1];
         synthCfg.loopFilter2 <= lf_q[2];
         synthCfg.chargePump <= lf_q[3];
      end
   end

   // Checks tie status to the search state, not to the status expression
   a_lock_needs_en: assert property (stsByte[0] |->
      state_q == spc_pkg::CAL_DONE && pfdLocked) else $error("lock early");
   a_cal_ok_state: assert property (calOk_q |->
      state_q == spc_pkg::CAL_DONE && !limHi_q) else $error("cal ok bad");
   a_limit_at_top: assert property ($rose(limHi_q) |->
      band_q == spc_pkg::BAND_MAX && $past(vcoSlow)) else $error("lim hi");
   a_recal_restart: assert property (ctrl_q[0] && $rose(ctrl_q[2]) |=>
      state_q == spc_pkg::CAL_SETTLE && band_q == spc_pkg::BAND_MID)
      else $error("recal not started");
   a_off_reads_zero: assert property (!ctrl_q[0] |=>
      !ctrl_q[0] |-> stsByte == 8'h00) else $error("status while off");
   a_byte_rate: assert property (rates.byteMhz ==
      rates.laneMbps / 22'd10) else $error("byte rate");
   a_pclk_rate: assert property (rates.pclkMhz ==
      rates.byteMhz >> 2 && rates.refMhz == rates.pclkMhz)
      else $error("pclk rate");
   a_frame_rate: assert property (rates.frameMhz ==
      (rates.byteMhz * 22'(rates.framePerProcClockRatio)) >> 2)
      else $error("frame rate");
   a_lane_rate: assert property (##1 rates.laneMbps ==
      ((22'($past(rateCfg_q[15:0])) * 22'd20) << $past(rateCfg_q[18]))
      >> ({1'b0, $past(rateCfg_q[17:16])} + {1'b0, $past(rateCfg_q[21:20])}))
      else $error("lane rate");
   a_div_map: assert property (refDiv_q[1:0] == 2'h1 |=>
      synthCfg.refDivideRatio == 3'h2) else $error("div map");
   a_ack_pulse: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1
      !ack_o) else $error("ack timing");
   c_cal_done: cover property (state_q == spc_pkg::CAL_DECIDE ##1 calOk_q);
   c_limit_high: cover property ($rose(limHi_q));
   c_irq_lock: cover property ($rose(locked) ##1 irq);
endmodule // spc_synth_ctrl
`default_nettype wire

// ### verification/spc_synth_ctrl_test.sv
// Self-checking bench for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
module spc_synth_ctrl_test;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] datW = 32'h0;
   logic [31:0] datR;
   logic ack;
   logic vcoSlow = 1'b0;
   logic pfdLocked = 1'b0;
   spc_pkg::spc_synth_cfg_t synthCfg;
   logic [5:0] vcoBand;
   spc_pkg::spc_rates_t rates;
   logic irq;
   int target = 0;
   int n_mismatch = 0;
   int compares = 0;
   logic [15:0] lfsr = 16'hb973;
   logic [31:0] regm [0:1023] = '{default: 32'h0};

   // Clock, 100 MHz
   always #5 sys_clk = ~sys_clk;

   spc_synth_ctrl i_spc_synth_ctrl (
      .sys_clk(sys_clk), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR),
      .ack_o(ack), .vcoSlow(vcoSlow), .pfdLocked(pfdLocked),
      .synthCfg(synthCfg), .vcoBand(vcoBand), .rates(rates), .irq(irq)
   );

   // Comparator stand-in: VCO is slow while the band is under target
   always @(posedge sys_clk) vcoSlow <= (int'(vcoBand) < target);

   // Verdict, the single exit point
   task automatic close_out;
      if (n_mismatch == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Port compare
   task automatic chk_port(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Classic cycle; ack and read data taken at the same edge
   task automatic bus(input logic w, input logic [9:0] idx,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'hf;
      datW <= d;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (n >= 20)
         chk_port("ack", 32'h1, {31'h0, ack});
      q = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      logic [31:0] q;
      regm[idx] = d;
      bus(1'b1, idx, d, q);
   endtask

   // Register read compare
   task automatic chk_reg(input logic [9:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 32'h0, q);
      compares++;
      if (q !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH reg %h expected %h seen %h", idx, exp, q);
      end
   endtask

   // Poll status; bounded since a band sweep is about 3300 cycles
   task automatic wait_cal(input logic [7:0] want);
      logic [31:0] q;
      int n;
      n = 0;
      do
      begin
         bus(1'b0, spc_pkg::IDX_STS, 32'h0, q);
         n++;
      end
      while ((q[7:0] & 8'h38) !== want && n < 3000);
      chk_port("calEnd", {24'h0, want}, {24'h0, q[7:0] & 8'h38});
   endtask

   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Main sequence
   initial
   begin : main
      logic [9:0] rdIdx [$] = '{spc_pkg::IDX_CTRL, spc_pkg::IDX_STS,
         spc_pkg::IDX_LF0, spc_pkg::IDX_REFDIV, spc_pkg::IDX_IRQSTS,
         spc_pkg::IDX_IRQMASK, spc_pkg::IDX_CP};
      logic [9:0] rwIdx [$] = '{spc_pkg::IDX_LF0, spc_pkg::IDX_LF0 + 10'h1,
         spc_pkg::IDX_LF0 + 10'h2, spc_pkg::IDX_CP};
      logic [31:0] recm [$] = '{32'h62, 32'hc9, 32'h0e, 32'h12};
      int planT [$] = '{35, 64, 0, 31};
      logic [7:0] planW [$] = '{8'h08, 8'h10, 8'h20, 8'h08};
      int planB [$] = '{0, 1, 2, 0};
      int planV [$] = '{35, 63, 0, 30};
      int lane, byteR, dac, i, m, l, f;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      // Reset state
      chk_port("vcoBand", 32'h20, {26'h0, vcoBand});
      chk_port("cfg", 32'h0, {31'h0, |synthCfg});
      chk_port("irq", 32'h0, {31'h0, irq});
      foreach (rdIdx[k])
         chk_reg(rdIdx[k], 32'h0);
      // Random filter values, recommended values last
      for (int k = 0; k < 4; k++)
      begin
         foreach (rwIdx[j])
         begin
            lfsr = step(lfsr);
            wr(rwIdx[j], k == 3 ? recm[j] : {24'h0, lfsr[7:0]});
            chk_reg(rwIdx[j], regm[rwIdx[j]]);
         end
      end
      chk_port("lf0", 32'h62, {24'h0, synthCfg.loopFilter0});
      chk_port("lf12cp", 32'hc90e12, {8'h0, synthCfg.loopFilter1,
         synthCfg.loopFilter2, synthCfg.chargePump});
      // Every divider code
      for (int c = 0; c < 4; c++)
      begin
         wr(spc_pkg::IDX_REFDIV, 32'(c));
         chk_reg(spc_pkg::IDX_REFDIV, regm[spc_pkg::IDX_REFDIV]);
         chk_port("divSel", c, {30'h0, synthCfg.divSelect});
         chk_port("divRatio", c == 2 ? 1 : c == 1 ? 2 : 4,
            {29'h0, synthCfg.refDivideRatio});
      end
      // Derived rates; dac kept a multiple of 64 so the model is exact
      for (int k = 0; k < 8; k++)
      begin
         lfsr = step(lfsr);
         dac = int'(lfsr & 16'h3fc0) + 64;
         i = int'(lfsr[1:0]);
         m = int'(lfsr[2]);
         l = int'(lfsr[4:3]);
         f = int'(lfsr[5]);
         lane = 20 * dac * (1 << m) / ((1 << i) * (1 << l));
         byteR = lane / 10;
         wr(spc_pkg::IDX_RATECFG,
            32'(dac + (i << 16) + (m << 18) + (l << 20) + (f << 24)));
         @(posedge sys_clk);
         chk_port("lane", lane, {10'h0, rates.laneMbps});
         chk_port("byte", byteR, {10'h0, rates.byteMhz});
         chk_port("pclk", byteR / 4, {10'h0, rates.pclkMhz});
         chk_port("frame", byteR >> f, {10'h0, rates.frameMhz});
         chk_port("fpp", 4 >> f, {29'h0, rates.framePerProcClockRatio});
         chk_port("ref", lane / 40, {10'h0, rates.refMhz});
         chk_reg(spc_pkg::IDX_LANE, lane);
      end
      // Calibration endings: ok, band top, band foot, ok again
      pfdLocked <= 1'b1;
      // Divider picked from the last lane rate, detector input kept in band
      wr(spc_pkg::IDX_REFDIV,
         lane < 2880 ? 32'h2 : lane < 5750 ? 32'h1 : 32'h0);
      foreach (planT[k])
      begin
         target <= planT[k];
         wr(spc_pkg::IDX_IRQSTS, 32'h1f);
         wr(spc_pkg::IDX_IRQMASK, 32'h1 << planB[k]);
         wr(spc_pkg::IDX_CTRL, 32'h1);
         wr(spc_pkg::IDX_CTRL, 32'h5);
         wait_cal(planW[k]);
         chk_port("band", planV[k], {26'h0, vcoBand});
         chk_port("synthEn", 32'h1, {31'h0, synthCfg.enable});
         chk_reg(spc_pkg::IDX_STS, {24'h0, planW[k]}
            | 32'(planW[k] == 8'h08));
         chk_port("irqSet", 32'h1, {31'h0, irq});
         wr(spc_pkg::IDX_IRQMASK, 32'h0);
         chk_port("irqMasked", 32'h0, {31'h0, irq});
         wr(spc_pkg::IDX_IRQMASK, 32'h1 << planB[k]);
         wr(spc_pkg::IDX_IRQSTS, 32'h1 << planB[k]);
         chk_port("irqClr", 32'h0, {31'h0, irq});
      end
      // Lock bit tracks the detector live; lock loss and gain are events
      wr(spc_pkg::IDX_IRQSTS, 32'h1f);
      wr(spc_pkg::IDX_IRQMASK, 32'h08);
      pfdLocked <= 1'b0;
      @(posedge sys_clk);
      chk_reg(spc_pkg::IDX_STS, 32'h08);
      pfdLocked <= 1'b1;
      @(posedge sys_clk);
      chk_reg(spc_pkg::IDX_STS, 32'h09);
      chk_reg(spc_pkg::IDX_IRQSTS, 32'h18);
      chk_port("irqLock", 32'h1, {31'h0, irq});
      // Disable drops every flag
      wr(spc_pkg::IDX_CTRL, 32'h0);
      chk_reg(spc_pkg::IDX_STS, 32'h0);
      chk_reg(spc_pkg::IDX_CTRL, regm[spc_pkg::IDX_CTRL]);
      // Unmapped and read-only places ignore writes
      wr(10'h3ff, 32'h5a);
      chk_reg(10'h3ff, 32'h0);
      wr(spc_pkg::IDX_STS, 32'hff);
      chk_reg(spc_pkg::IDX_STS, 32'h0);
      close_out;
   end

   // Watchdog, far beyond the four band sweeps
   initial
   begin
      #400_000;
      n_mismatch++;
      close_out;
   end
endmodule // spc_synth_ctrl_test
`default_nettype wire
